// [common/sxe_pkg.sv]
/*
  Shared constants, types and helpers for the skip, table-read and XOR execution unit.
  Assumes one system clock domain; program memory is 1K words of 14 bits in 256-word pages.
*/
package sxe_pkg;

  // --------------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ROM_W = 14;
  localparam int ROM_ADDR_W = 10;
  localparam int PAGE_W = 2;
  localparam int PTR_W = 8;
  localparam int TBL_HIGH_W = 6;
  localparam int BIT_SEL_W = 3;
  localparam int STATUS_W = 6;

  // --------------------------------------------------------------------------
  // fixed values
  // --------------------------------------------------------------------------
  localparam logic [PAGE_W-1:0] LAST_PAGE = 2'h3;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [TBL_HIGH_W-1:0] TBL_HIGH_RESET = 6'h00;
  localparam logic [ROM_ADDR_W-1:0] ROM_ADDR_RESET = 10'h000;
  localparam logic FLAG_RESET = 1'h0;

  // --------------------------------------------------------------------------
  // status write bit positions
  // --------------------------------------------------------------------------
  localparam int FLAG_CARRY_POS = 0;
  localparam int FLAG_AUX_CARRY_POS = 1;
  localparam int FLAG_ZERO_POS = 2;
  localparam int FLAG_OVERFLOW_POS = 3;
  localparam int FLAG_POWER_DOWN_POS = 4;
  localparam int FLAG_TIMEOUT_POS = 5;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_SWAP_NIBBLES_TO_ACC,
    OP_SKIP_IF_ZERO,
    OP_MOVE_SKIP_IF_ZERO,
    OP_SKIP_IF_BIT_ZERO,
    OP_TABLE_READ_CURRENT_PAGE,
    OP_TABLE_READ_LAST_PAGE,
    OP_XOR_ACC_MEM,
    OP_XOR_TO_MEMORY,
    OP_XOR_ACC_IMM
  } sxe_op_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SKIP_DUMMY,
    ST_TABLE_FETCH
  } sxe_state_type;

  function automatic logic sxe_is_zero(input logic [DATA_W-1:0] value);
    sxe_is_zero = (value == 8'h00);
  endfunction

endpackage

// [core/sxe_exec_unit.sv]
/*
  Execution unit for nibble swap, skip tests, table reads and XOR instructions.
  Owns the accumulator, the status flags and the table-high latch.
  Assumes the core holds the data address, memory read data and table pointer stable while
  the unit is busy, and that program memory answers combinationally while o_rom_rd is high.
*/
`timescale 1ns/1ps

// Overview of operation
// - swap nibbles of memory byte into accumulator
// - skip next instruction when byte is zero
// - copy byte to accumulator, skip if zero
// - skip next instruction when selected bit zero
// - skip discards prefetch, adds one dummy cycle
// - table read from current page
// - table read from last page
// - accumulator gets accumulator xor memory
// - memory gets accumulator xor memory
// - accumulator gets accumulator xor immediate
// - xor sets zero only, other flags kept
module sxe_exec_unit (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_op_valid,
  input wire sxe_pkg::sxe_op_type i_op_code,
  input wire logic [sxe_pkg::DATA_W-1:0] i_mem_data,
  input wire logic [sxe_pkg::DATA_W-1:0] i_imm,
  input wire logic [sxe_pkg::BIT_SEL_W-1:0] i_bit_sel,
  input wire logic [sxe_pkg::PAGE_W-1:0] i_pc_page,
  input wire logic [sxe_pkg::PTR_W-1:0] i_table_pointer,
  input wire logic [sxe_pkg::ROM_W-1:0] i_rom_data,
  input wire logic i_acc_load,
  input wire logic [sxe_pkg::DATA_W-1:0] i_acc_wdata,
  input wire logic i_status_load,
  input wire logic [sxe_pkg::STATUS_W-1:0] i_status_wdata,
  output logic o_ready,
  output logic o_done,
  output logic o_discard,
  output logic o_rom_rd,
  output logic [sxe_pkg::ROM_ADDR_W-1:0] o_rom_addr,
  output logic o_mem_wr,
  output logic [sxe_pkg::DATA_W-1:0] o_mem_wdata,
  output logic [sxe_pkg::DATA_W-1:0] o_acc,
  output logic [sxe_pkg::TBL_HIGH_W-1:0] o_table_high_latch,
  output logic o_zero_flag,
  output logic o_carry_flag,
  output logic o_aux_carry_flag,
  output logic o_overflow_flag,
  output logic o_timeout_flag,
  output logic o_power_down_flag
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    sxe_pkg::sxe_state_type state;
    logic ready;
    logic done;
    logic discard;
    logic rom_rd;
    logic [sxe_pkg::ROM_ADDR_W-1:0] rom_addr;
    logic mem_wr;
    logic [sxe_pkg::DATA_W-1:0] mem_wdata;
    logic [sxe_pkg::DATA_W-1:0] acc;
    logic [sxe_pkg::TBL_HIGH_W-1:0] tbl_high;
    logic zero;
    logic carry;
    logic aux_carry;
    logic overflow;
    logic timeout;
    logic power_down;
  } sxe_regs_type;

  sxe_regs_type cur;
  sxe_regs_type next_cur;

  logic [7:0] swap_val;
  logic [7:0] xor_mem;
  logic [7:0] xor_imm;
  logic mem_zero;
  logic bit_zero;
  logic [9:0] table_addr;
  logic op_take;
  logic is_last_page;

  assign op_take = i_op_valid && (cur.state == sxe_pkg::ST_IDLE);
  assign is_last_page = (i_op_code == sxe_pkg::OP_TABLE_READ_LAST_PAGE);

  // --------------------------------------------------------------------------
  // data path
  // --------------------------------------------------------------------------
  sxe_logic_unit u_logic (
    .i_acc(cur.acc),
    .i_mem_data(i_mem_data),
    .i_imm(i_imm),
    .i_bit_sel(i_bit_sel),
    .o_swap(swap_val),
    .o_xor_mem(xor_mem),
    .o_xor_imm(xor_imm),
    .o_mem_zero(mem_zero),
    .o_bit_zero(bit_zero)
  );

  sxe_table_addr u_table_addr (
    .i_last_page(is_last_page),
    .i_pc_page(i_pc_page),
    .i_table_pointer(i_table_pointer),
    .o_rom_addr(table_addr)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'h0;
    next_cur.discard = 1'h0;
    next_cur.mem_wr = 1'h0;
    next_cur.rom_rd = 1'h0;
    // core-side loads; an executing instruction overrides the fields that it writes
    if (i_acc_load) begin
      next_cur.acc = i_acc_wdata;
    end
    if (i_status_load) begin
      next_cur.carry = i_status_wdata[sxe_pkg::FLAG_CARRY_POS];
      next_cur.aux_carry = i_status_wdata[sxe_pkg::FLAG_AUX_CARRY_POS];
      next_cur.zero = i_status_wdata[sxe_pkg::FLAG_ZERO_POS];
      next_cur.overflow = i_status_wdata[sxe_pkg::FLAG_OVERFLOW_POS];
      next_cur.power_down = i_status_wdata[sxe_pkg::FLAG_POWER_DOWN_POS];
      next_cur.timeout = i_status_wdata[sxe_pkg::FLAG_TIMEOUT_POS];
    end
    unique case (cur.state)
      sxe_pkg::ST_IDLE: begin
        if (i_op_valid) begin
          unique case (i_op_code)
            sxe_pkg::OP_NONE: begin
              next_cur.done = 1'h0;
            end
            sxe_pkg::OP_SWAP_NIBBLES_TO_ACC: begin
              next_cur.acc = swap_val;
              next_cur.done = 1'h1;
            end
            sxe_pkg::OP_SKIP_IF_ZERO: begin
              if (mem_zero) begin
                next_cur.state = sxe_pkg::ST_SKIP_DUMMY;
                next_cur.discard = 1'h1;
              end else begin
                next_cur.done = 1'h1;
              end
            end
            sxe_pkg::OP_MOVE_SKIP_IF_ZERO: begin
              next_cur.acc = i_mem_data;
              if (mem_zero) begin
                next_cur.state = sxe_pkg::ST_SKIP_DUMMY;
                next_cur.discard = 1'h1;
              end else begin
                next_cur.done = 1'h1;
              end
            end
            sxe_pkg::OP_SKIP_IF_BIT_ZERO: begin
              if (bit_zero) begin
                next_cur.state = sxe_pkg::ST_SKIP_DUMMY;
                next_cur.discard = 1'h1;
              end else begin
                next_cur.done = 1'h1;
              end
            end
            sxe_pkg::OP_TABLE_READ_CURRENT_PAGE, sxe_pkg::OP_TABLE_READ_LAST_PAGE: begin
              next_cur.state = sxe_pkg::ST_TABLE_FETCH;
              next_cur.rom_rd = 1'h1;
              next_cur.rom_addr = table_addr;
            end
            sxe_pkg::OP_XOR_ACC_MEM: begin
              next_cur.acc = xor_mem;
              next_cur.zero = sxe_pkg::sxe_is_zero(xor_mem);
              next_cur.done = 1'h1;
            end
            sxe_pkg::OP_XOR_TO_MEMORY: begin
              next_cur.mem_wr = 1'h1;
              next_cur.mem_wdata = xor_mem;
              next_cur.zero = sxe_pkg::sxe_is_zero(xor_mem);
              next_cur.done = 1'h1;
            end
            sxe_pkg::OP_XOR_ACC_IMM: begin
              next_cur.acc = xor_imm;
              next_cur.zero = sxe_pkg::sxe_is_zero(xor_imm);
              next_cur.done = 1'h1;
            end
            default: begin
              next_cur.done = 1'h0;
            end
          endcase
        end
      end
      sxe_pkg::ST_SKIP_DUMMY: begin
        // dummy cycle replaces the discarded prefetch
        next_cur.state = sxe_pkg::ST_IDLE;
        next_cur.done = 1'h1;
      end
      sxe_pkg::ST_TABLE_FETCH: begin
        next_cur.mem_wr = 1'h1;
        next_cur.mem_wdata = i_rom_data[7:0];
        next_cur.tbl_high = i_rom_data[13:8];
        next_cur.state = sxe_pkg::ST_IDLE;
        next_cur.done = 1'h1;
      end
      default: begin
        next_cur.state = sxe_pkg::ST_IDLE;
      end
    endcase
    next_cur.ready = (next_cur.state == sxe_pkg::ST_IDLE);
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cur.state <= sxe_pkg::ST_IDLE;
      cur.ready <= 1'h1;
      cur.done <= 1'h0;
      cur.discard <= 1'h0;
      cur.rom_rd <= 1'h0;
      cur.rom_addr <= sxe_pkg::ROM_ADDR_RESET;
      cur.mem_wr <= 1'h0;
      cur.mem_wdata <= sxe_pkg::DATA_RESET;
      cur.acc <= sxe_pkg::ACC_RESET;
      cur.tbl_high <= sxe_pkg::TBL_HIGH_RESET;
      cur.zero <= sxe_pkg::FLAG_RESET;
      cur.carry <= sxe_pkg::FLAG_RESET;
      cur.aux_carry <= sxe_pkg::FLAG_RESET;
      cur.overflow <= sxe_pkg::FLAG_RESET;
      cur.timeout <= sxe_pkg::FLAG_RESET;
      cur.power_down <= sxe_pkg::FLAG_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign o_ready = cur.ready;
  assign o_done = cur.done;
  assign o_discard = cur.discard;
  assign o_rom_rd = cur.rom_rd;
  assign o_rom_addr = cur.rom_addr;
  assign o_mem_wr = cur.mem_wr;
  assign o_mem_wdata = cur.mem_wdata;
  assign o_acc = cur.acc;
  assign o_table_high_latch = cur.tbl_high;
  assign o_zero_flag = cur.zero;
  assign o_carry_flag = cur.carry;
  assign o_aux_carry_flag = cur.aux_carry;
  assign o_overflow_flag = cur.overflow;
  assign o_timeout_flag = cur.timeout;
  assign o_power_down_flag = cur.power_down;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking ast_clk @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  logic [4:0] other_flags;
  logic [5:0] all_flags;
  logic [5:0] rom_high;
  logic skip_cond;
  logic is_xor_op;
  logic xor_zero;

  assign other_flags = {cur.carry, cur.aux_carry, cur.overflow, cur.timeout, cur.power_down};
  assign all_flags = {cur.zero, other_flags};
  assign rom_high = i_rom_data[13:8];
  assign is_xor_op = (i_op_code == sxe_pkg::OP_XOR_ACC_MEM) || (i_op_code == sxe_pkg::OP_XOR_TO_MEMORY)
                     || (i_op_code == sxe_pkg::OP_XOR_ACC_IMM);
  assign xor_zero = (i_op_code == sxe_pkg::OP_XOR_ACC_IMM) ? ((cur.acc ^ i_imm) == 8'h00)
                    : ((cur.acc ^ i_mem_data) == 8'h00);
  assign skip_cond = ((i_op_code == sxe_pkg::OP_SKIP_IF_ZERO) && (i_mem_data == 8'h00))
                     || ((i_op_code == sxe_pkg::OP_MOVE_SKIP_IF_ZERO) && (i_mem_data == 8'h00))
                     || ((i_op_code == sxe_pkg::OP_SKIP_IF_BIT_ZERO) && !i_mem_data[i_bit_sel]);

  sequence seq_dummy_then_done;
    o_discard && !o_ready ##1 o_done && o_ready && !o_discard;
  endsequence

  sequence seq_fetch_then_write;
    o_rom_rd && !o_ready ##1 o_mem_wr && o_done && (o_mem_wdata == $past(i_rom_data[7:0]))
      && (o_table_high_latch == $past(rom_high));
  endsequence

  AST_SWAP_TO_ACC: assert property (op_take && i_op_code == sxe_pkg::OP_SWAP_NIBBLES_TO_ACC
    |=> o_acc == {$past(i_mem_data[3:0]), $past(i_mem_data[7:4])} && !o_mem_wr && o_done)
    else $error("swap result wrong");
  AST_BYTE_SKIP: assert property (op_take && i_op_code == sxe_pkg::OP_SKIP_IF_ZERO
    |=> (o_discard == $past(i_mem_data == 8'h00)) && (o_done == !$past(i_mem_data == 8'h00)))
    else $error("byte zero skip wrong");
  AST_MOVE_SKIP: assert property (op_take && i_op_code == sxe_pkg::OP_MOVE_SKIP_IF_ZERO
    |=> o_acc == $past(i_mem_data) && (o_discard == $past(i_mem_data == 8'h00)))
    else $error("move and skip wrong");
  AST_BIT_SKIP: assert property (op_take && i_op_code == sxe_pkg::OP_SKIP_IF_BIT_ZERO
    |=> o_discard == $past(!i_mem_data[i_bit_sel]))
    else $error("bit skip wrong");
  AST_SKIP_TWO_CYCLES: assert property (op_take && skip_cond |=> seq_dummy_then_done)
    else $error("skip not two cycles");
  AST_NO_SKIP_ONE_CYCLE: assert property (op_take && !skip_cond && !is_last_page
    && i_op_code != sxe_pkg::OP_TABLE_READ_CURRENT_PAGE && i_op_code != sxe_pkg::OP_NONE
    |=> o_done && o_ready && !o_discard)
    else $error("no skip not one cycle");
  AST_TABLE_CURRENT: assert property (op_take && i_op_code == sxe_pkg::OP_TABLE_READ_CURRENT_PAGE
    |=> o_rom_addr == {$past(i_pc_page), $past(i_table_pointer)} ##0 seq_fetch_then_write)
    else $error("current page table read wrong");
  AST_TABLE_LAST: assert property (op_take && is_last_page
    |=> o_rom_addr == {sxe_pkg::LAST_PAGE, $past(i_table_pointer)} ##0 seq_fetch_then_write)
    else $error("last page table read wrong");
  AST_XOR_ACC: assert property (op_take && i_op_code == sxe_pkg::OP_XOR_ACC_MEM
    |=> o_acc == $past(cur.acc ^ i_mem_data) && !o_mem_wr)
    else $error("xor into accumulator wrong");
  AST_XOR_MEM: assert property (op_take && i_op_code == sxe_pkg::OP_XOR_TO_MEMORY && !i_acc_load
    |=> o_mem_wr && o_mem_wdata == $past(cur.acc ^ i_mem_data) && $stable(o_acc))
    else $error("xor into memory wrong");
  AST_XOR_IMM: assert property (op_take && i_op_code == sxe_pkg::OP_XOR_ACC_IMM
    |=> o_acc == $past(cur.acc ^ i_imm))
    else $error("xor immediate wrong");
  AST_XOR_FLAGS: assert property (op_take && is_xor_op && !i_status_load
    |=> o_zero_flag == $past(xor_zero) && $stable(other_flags))
    else $error("xor flag update wrong");
  AST_NO_FLAG_CHANGE: assert property (op_take && !is_xor_op && !i_status_load
    |=> $stable(all_flags))
    else $error("flags changed by non-xor op");
  AST_BUSY_KEEPS_FLAGS: assert property (!o_ready && !i_status_load |=> $stable(all_flags))
    else $error("flags changed in second cycle");

endmodule

// [core/sxe_logic_unit.sv]
/*
  Combinational data path: nibble swap, XOR results and zero tests.
  Assumes operands come from logic on the same clock.
*/
`timescale 1ns/1ps
module sxe_logic_unit (
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_mem_data,
  input wire logic [7:0] i_imm,
  input wire logic [2:0] i_bit_sel,
  output logic [7:0] o_swap,
  output logic [7:0] o_xor_mem,
  output logic [7:0] o_xor_imm,
  output logic o_mem_zero,
  output logic o_bit_zero
);

  always_comb begin
    o_swap = {i_mem_data[3:0], i_mem_data[7:4]};
    o_xor_mem = i_acc ^ i_mem_data;
    o_xor_imm = i_acc ^ i_imm;
    o_mem_zero = sxe_pkg::sxe_is_zero(i_mem_data);
    o_bit_zero = ~i_mem_data[i_bit_sel];
  end

endmodule

// [core/sxe_table_addr.sv]
/*
  Program-memory address former for table reads.
  Assumes the page of the current program counter is supplied by the core.
*/
`timescale 1ns/1ps
module sxe_table_addr (
  input wire logic i_last_page,
  input wire logic [1:0] i_pc_page,
  input wire logic [7:0] i_table_pointer,
  output logic [9:0] o_rom_addr
);

  always_comb begin
    if (i_last_page) begin
      o_rom_addr = {sxe_pkg::LAST_PAGE, i_table_pointer};
    end else begin
      o_rom_addr = {i_pc_page, i_table_pointer};
    end
  end

endmodule

// [testbench/sxe_exec_unit_test.sv]
/*
  Self-checking bench for the skip, table-read and xor execution unit.
  Assumes sxe_pkg is compiled first; the bench drives every unit input at the falling edge
  and keeps its own copy of accumulator and flags to predict results.
*/
`timescale 1ns/1ps
module sxe_exec_unit_test;
  // ----------------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------------
  localparam int LIMIT = 20000;
  logic i_sys_clk, i_rst_b, i_op_valid, i_acc_load, i_status_load;
  sxe_pkg::sxe_op_type i_op_code;
  logic [7:0] i_mem_data, i_imm, i_table_pointer, i_acc_wdata;
  logic [2:0] i_bit_sel;
  logic [1:0] i_pc_page;
  logic [13:0] i_rom_data;
  logic [5:0] i_status_wdata;
  logic o_ready, o_done, o_discard, o_rom_rd, o_mem_wr;
  logic [9:0] o_rom_addr;
  logic [7:0] o_mem_wdata, o_acc;
  logic [5:0] o_table_high_latch;
  logic o_zero_flag, o_carry_flag, o_aux_carry_flag, o_overflow_flag, o_timeout_flag, o_power_down_flag;
  logic [5:0] got_st;
  logic [7:0] exp_acc;
  logic [5:0] exp_st;
  int fails, check_count, cycles;

  assign got_st = {o_timeout_flag, o_power_down_flag, o_overflow_flag, o_zero_flag, o_aux_carry_flag, o_carry_flag};

  sxe_exec_unit dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_op_valid(i_op_valid), .i_op_code(i_op_code),
    .i_mem_data(i_mem_data), .i_imm(i_imm), .i_bit_sel(i_bit_sel), .i_pc_page(i_pc_page),
    .i_table_pointer(i_table_pointer), .i_rom_data(i_rom_data), .i_acc_load(i_acc_load),
    .i_acc_wdata(i_acc_wdata), .i_status_load(i_status_load), .i_status_wdata(i_status_wdata),
    .o_ready(o_ready), .o_done(o_done), .o_discard(o_discard), .o_rom_rd(o_rom_rd), .o_rom_addr(o_rom_addr),
    .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_acc(o_acc), .o_table_high_latch(o_table_high_latch),
    .o_zero_flag(o_zero_flag), .o_carry_flag(o_carry_flag), .o_aux_carry_flag(o_aux_carry_flag),
    .o_overflow_flag(o_overflow_flag), .o_timeout_flag(o_timeout_flag), .o_power_down_flag(o_power_down_flag));

  // ----------------------------------------------------------------------------
  // clock, watchdog, reporting
  // ----------------------------------------------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_bit(input string name, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic chk_val(input string name, input logic [13:0] e, input logic [13:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  // ----------------------------------------------------------------------------
  // prediction
  // ----------------------------------------------------------------------------
  function automatic logic exp_skip(input sxe_pkg::sxe_op_type op, input logic [7:0] m, input logic [2:0] b);
    case (op)
      sxe_pkg::OP_SKIP_IF_ZERO, sxe_pkg::OP_MOVE_SKIP_IF_ZERO: exp_skip = (m == 8'h00);
      sxe_pkg::OP_SKIP_IF_BIT_ZERO: exp_skip = !m[b];
      default: exp_skip = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] new_acc(input sxe_pkg::sxe_op_type op, input logic [7:0] a, input logic [7:0] m,
                                         input logic [7:0] x);
    case (op)
      sxe_pkg::OP_SWAP_NIBBLES_TO_ACC: new_acc = {m[3:0], m[7:4]};
      sxe_pkg::OP_MOVE_SKIP_IF_ZERO: new_acc = m;
      sxe_pkg::OP_XOR_ACC_MEM: new_acc = a ^ m;
      sxe_pkg::OP_XOR_ACC_IMM: new_acc = a ^ x;
      default: new_acc = a;
    endcase
  endfunction

  // ----------------------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------------------
  task automatic do_reset(input int n);
    i_op_valid = 1'b0;
    i_rst_b = 1'b0;
    repeat (n) @(negedge i_sys_clk);
    chk_bit("ready", 1'b1, o_ready);
    chk_bit("done", 1'b0, o_done);
    chk_val("acc", 14'h0000, o_acc);
    chk_val("flags", 14'h0000, got_st);
    chk_val("latch", 14'h0000, o_table_high_latch);
    i_rst_b = 1'b1;
    exp_acc = 8'h00;
    exp_st = 6'h00;
  endtask

  task automatic preload(input logic [7:0] a, input logic [5:0] st);
    i_op_valid = 1'b0;
    i_acc_load = 1'b1;
    i_acc_wdata = a;
    i_status_load = 1'b1;
    i_status_wdata = st;
    @(negedge i_sys_clk);
    i_acc_load = 1'b0;
    i_status_load = 1'b0;
    exp_acc = a;
    exp_st = st;
  endtask

  // valid stays high until the next caller changes it: a request held through
  // a busy cycle must be refused, and back to back issue is exercised
  task automatic exec(input sxe_pkg::sxe_op_type op, input logic [7:0] mem, input logic [7:0] imm,
                      input logic [2:0] bsel, input logic [1:0] page, input logic [7:0] ptr, input logic [13:0] rom);
    logic skip;
    logic tbl;
    logic last;
    logic [7:0] xr;
    skip = exp_skip(op, mem, bsel);
    last = (op == sxe_pkg::OP_TABLE_READ_LAST_PAGE);
    tbl = last || (op == sxe_pkg::OP_TABLE_READ_CURRENT_PAGE);
    xr = (op == sxe_pkg::OP_XOR_ACC_IMM) ? exp_acc ^ imm : exp_acc ^ mem;
    i_op_valid = 1'b1;
    i_op_code = op;
    i_mem_data = mem;
    i_imm = imm;
    i_bit_sel = bsel;
    i_pc_page = page;
    i_table_pointer = ptr;
    i_rom_data = ~rom;
    @(negedge i_sys_clk);
    i_mem_data = ~mem;
    chk_bit("done", !(skip || tbl) && (op != sxe_pkg::OP_NONE), o_done);
    chk_bit("ready", !(skip || tbl), o_ready);
    chk_bit("rom_rd", tbl, o_rom_rd);
    chk_bit("mem_wr", op == sxe_pkg::OP_XOR_TO_MEMORY, o_mem_wr);
    case (op)
      sxe_pkg::OP_SKIP_IF_ZERO: chk_bit("discard", skip, o_discard);
      sxe_pkg::OP_MOVE_SKIP_IF_ZERO: chk_bit("discard", skip, o_discard);
      sxe_pkg::OP_SKIP_IF_BIT_ZERO: chk_bit("discard", skip, o_discard);
      default: chk_bit("discard", 1'b0, o_discard);
    endcase
    if (op == sxe_pkg::OP_XOR_TO_MEMORY) chk_val("mem_wdata", xr, o_mem_wdata);
    if (tbl && !last) chk_val("rom_addr", {page, ptr}, o_rom_addr);
    if (last) chk_val("rom_addr", {sxe_pkg::LAST_PAGE, ptr}, o_rom_addr);
    if (tbl) i_rom_data = rom;
    if (skip || tbl) begin
      @(negedge i_sys_clk);
      i_rom_data = ~rom;
      chk_bit("done", 1'b1, o_done);
      chk_bit("ready", 1'b1, o_ready);
      chk_bit("discard", 1'b0, o_discard);
      chk_bit("mem_wr", tbl, o_mem_wr);
    end
    if (tbl) begin
      chk_val("mem_wdata", rom[7:0], o_mem_wdata);
      chk_val("latch", rom[13:8], o_table_high_latch);
    end
    exp_acc = new_acc(op, exp_acc, mem, imm);
    case (op)
      sxe_pkg::OP_SWAP_NIBBLES_TO_ACC: chk_val("acc", exp_acc, o_acc);
      sxe_pkg::OP_MOVE_SKIP_IF_ZERO: chk_val("acc", exp_acc, o_acc);
      sxe_pkg::OP_XOR_ACC_MEM: chk_val("acc", exp_acc, o_acc);
      sxe_pkg::OP_XOR_ACC_IMM: chk_val("acc", exp_acc, o_acc);
      default: chk_val("acc", exp_acc, o_acc);
    endcase
    if (op == sxe_pkg::OP_XOR_ACC_MEM || op == sxe_pkg::OP_XOR_TO_MEMORY || op == sxe_pkg::OP_XOR_ACC_IMM) begin
      exp_st[sxe_pkg::FLAG_ZERO_POS] = (xr == 8'h00);
      chk_val("flags", exp_st, got_st);
    end else begin
      chk_val("flags", exp_st, got_st);
    end
  endtask

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    sxe_pkg::sxe_op_type op;
    logic [7:0] m;
    i_rst_b = 1'b0;
    i_op_valid = 1'b0;
    i_op_code = sxe_pkg::OP_NONE;
    i_mem_data = 8'h00;
    i_imm = 8'h00;
    i_bit_sel = 3'h0;
    i_pc_page = 2'h0;
    i_table_pointer = 8'h00;
    i_rom_data = 14'h0000;
    i_acc_load = 1'b0;
    i_acc_wdata = 8'h00;
    i_status_load = 1'b0;
    i_status_wdata = 6'h00;
    fails = 0;
    check_count = 0;
    cycles = 0;
    void'($urandom(56338));
    @(negedge i_sys_clk);
    do_reset(12);
    // corner cases, mostly back to back
    preload(8'h3c, 6'h3f);
    exec(sxe_pkg::OP_SWAP_NIBBLES_TO_ACC, 8'ha5, 8'h00, 3'h0, 2'h0, 8'h00, 14'h0000);
    exec(sxe_pkg::OP_SKIP_IF_ZERO, 8'h00, 8'h00, 3'h0, 2'h0, 8'h00, 14'h0000);
    exec(sxe_pkg::OP_SKIP_IF_ZERO, 8'h80, 8'h00, 3'h0, 2'h0, 8'h00, 14'h0000);
    exec(sxe_pkg::OP_MOVE_SKIP_IF_ZERO, 8'h00, 8'h00, 3'h0, 2'h0, 8'h00, 14'h0000);
    exec(sxe_pkg::OP_MOVE_SKIP_IF_ZERO, 8'h01, 8'h00, 3'h0, 2'h0, 8'h00, 14'h0000);
    for (int b = 0; b < 8; b++) begin
      exec(sxe_pkg::OP_SKIP_IF_BIT_ZERO, ~(8'h01 << b), 8'h00, 3'(b), 2'h0, 8'h00, 14'h0000);
      exec(sxe_pkg::OP_SKIP_IF_BIT_ZERO, 8'h01 << b, 8'h00, 3'(b), 2'h0, 8'h00, 14'h0000);
    end
    for (int p = 0; p < 4; p++) begin
      exec(sxe_pkg::OP_TABLE_READ_CURRENT_PAGE, 8'h00, 8'h00, 3'h0, 2'(p), 8'hff, 14'h3fff);
      exec(sxe_pkg::OP_TABLE_READ_LAST_PAGE, 8'h00, 8'h00, 3'h0, 2'(p), 8'h00, 14'h2a55);
    end
    exec(sxe_pkg::OP_XOR_ACC_MEM, 8'h01, 8'h00, 3'h0, 2'h0, 8'h00, 14'h0000);
    preload(8'h5a, 6'h3b);
    exec(sxe_pkg::OP_XOR_TO_MEMORY, 8'h5a, 8'h00, 3'h0, 2'h0, 8'h00, 14'h0000);
    exec(sxe_pkg::OP_XOR_ACC_IMM, 8'h00, 8'h5a, 3'h0, 2'h0, 8'h00, 14'h0000);
    exec(sxe_pkg::OP_XOR_ACC_MEM, 8'h5a, 8'h00, 3'h0, 2'h0, 8'h00, 14'h0000);
    exec(sxe_pkg::OP_NONE, 8'h00, 8'h00, 3'h0, 2'h0, 8'h00, 14'h0000);
    // reset in mid-run, then random traffic
    do_reset(2);
    for (int n = 0; n < 400; n++) begin
      if ($urandom_range(0, 3) == 0) preload(8'($urandom), 6'($urandom));
      op = sxe_pkg::sxe_op_type'($urandom_range(0, 9));
      m = ($urandom_range(0, 3) == 0) ? 8'h00 : 8'($urandom);
      exec(op, m, 8'($urandom), 3'($urandom), 2'($urandom), 8'($urandom), 14'($urandom));
    end
    i_op_valid = 1'b0;
    @(negedge i_sys_clk);
    final_report();
  end
endmodule
